/* File: flash_reset_pkg.sv */
// Package with constants and carrier types for the flash reset and hold controller.
package flash_reset_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned SOFT_RESET_TIME_US = 300;
   localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_TIME_US * (CLK_HZ / 1_000_000));
   localparam int unsigned RESET_PULSE_MIN_WIDTH_NS = 1000;
   localparam int unsigned RESET_PULSE_CYCLES =
      ((RESET_PULSE_MIN_WIDTH_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
   localparam logic [7:0] CMD_ENABLE_RESET = 8'h66;
   localparam logic [7:0] CMD_RESET = 8'h99;
   localparam logic [3:0] PULSE_RESET_PATTERN = 4'h5;
   localparam int unsigned CNT_W = 16;

   typedef enum logic [1:0] {
      ST_POR = 2'b00,
      ST_IDLE = 2'b01,
      ST_SOFT_WAIT = 2'b11
   } dev_state_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic pause_n;
      logic reset_n;
      logic ded_reset_n;
   } pins_t;

   typedef struct packed {
      logic quad_enable;
      logic pause_or_reset_sel;
      logic four_wire_command_mode;
   } cfg_t;
endpackage : flash_reset_pkg

/* File: serial_flash_reset_hold_ctrl.sv */
// Reset, select and pause control for a serial flash host interface.
`default_nettype none

// Behaviour
// - Stay deselected until first chip select fall.
// - Ignore commands during power-on reset; then reset.
// - Power-on reset reassert stops command response.
// - Chip select low means selected and active.
// - Standby when deselected unless write cycle runs.
// - Pause only when quad and select zero.
// - Pause tri-states output, freezes clock position.
// - Pause starts selected; deselect aborts everything.
// - Pause edges qualified by serial clock low.
// - Commands 66h then 99h request reset.
// - Soft reset takes 300 us, rejects commands.
// - Select bit chooses pause or reset pin.
// - Low reset pin resets, blocks commands.
// - Quad enable disables pause and shared-pin reset functions.
// - Dedicated reset pin ignores configuration bits.
// - Hardware reset overrides all inputs but power-on reset.
// - Chip select rising samples 0101 trigger reset.
// - Serial clock edge abandons four-pulse sequence.
// - No output before first clock edge of selection.
// - Quad enable makes pins data lines.
module serial_flash_reset_hold_ctrl #(
   parameter int unsigned SOFT_RESET_CYCLES_P = flash_reset_pkg::SOFT_RESET_CYCLES
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic por_active,
   input wire flash_reset_pkg::pins_t pins,
   input wire flash_reset_pkg::cfg_t cfg,
   input wire logic write_busy,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic selected,
   output logic active_power,
   output logic standby,
   output logic pause_active,
   output logic so_oe,
   output logic out_allowed,
   output logic accept_cmds,
   output logic iface_reset,
   output logic soft_reset_busy,
   output logic [1:0] reset_cause
);
   import flash_reset_pkg::*;

   pins_t pins_s1_reg;
   pins_t pins_s2_reg;
   pins_t pins_d_reg;
   logic por_s1_reg;
   logic por_s2_reg;
   dev_state_t state_reg;
   logic armed_reg;
   logic sel_reg;
   logic pause_reg;
   logic first_edge_reg;
   logic en_reset_reg;
   logic [CNT_W-1:0] soft_cnt_reg;
   logic [CNT_W-1:0] pin_low_cnt_reg;
   logic [2:0] pulse_cnt_reg;
   logic [3:0] pulse_bits_reg;
   logic pulse_sck_seen_reg;
   logic iface_reset_reg;
   logic [1:0] reset_cause_reg;

   logic cs_fall;
   logic cs_rise;
   logic sck_edge;
   logic pause_pin_en;
   logic reset_pin_en;
   logic shared_reset_low;
   logic any_reset_low;
   logic hw_reset_fire;
   logic pulse_reset_fire;
   logic soft_reset_fire;

   // Edge decoding is shared by chip select and serial clock.
   function automatic logic went_low(input logic was, input logic cur);
      return was & ~cur;
   endfunction : went_low

   function automatic logic went_high(input logic was, input logic cur);
      return ~was & cur;
   endfunction : went_high

   // The shared pin has one role at a time; quad mode takes it over as a data line.
   function automatic logic shared_pin_pauses(input cfg_t c);
      return ~c.quad_enable & ~c.pause_or_reset_sel;
   endfunction : shared_pin_pauses

   function automatic logic shared_pin_resets(input cfg_t c);
      return ~c.quad_enable & c.pause_or_reset_sel;
   endfunction : shared_pin_resets

   // A command counts only when it is offered while commands are accepted.
   function automatic logic cmd_match(input logic taken, input logic [7:0] code, input logic [7:0] want);
      return taken && (code == want);
   endfunction : cmd_match

   // Four-pulse history extended by the data level sampled at a chip select rise.
   function automatic logic [3:0] pulse_shift(input logic [3:0] bits, input logic si);
      return {bits[2:0], si};
   endfunction : pulse_shift

   // Two-flop synchronisers; only the second stage is looked at.
   // The third stage holds the previous level for edge detection only.
   // Reset to all-high levels, so no false edge follows reset on the lines that idle high.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pins_s1_reg <= '1;
         pins_s2_reg <= '1;
         pins_d_reg <= '1;
      end else begin
         pins_s1_reg <= pins;
         pins_s2_reg <= pins_s1_reg;
         pins_d_reg <= pins_s2_reg;
      end
   end

   // The power-on indication resets to asserted.
   // Nothing is accepted until its release has passed both stages.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         por_s1_reg <= 1'b1;
         por_s2_reg <= 1'b1;
      end else begin
         por_s1_reg <= por_active;
         por_s2_reg <= por_s1_reg;
      end
   end

   assign cs_fall = went_low(pins_d_reg.cs_n, pins_s2_reg.cs_n);
   assign cs_rise = went_high(pins_d_reg.cs_n, pins_s2_reg.cs_n);
   assign sck_edge = went_low(pins_d_reg.sck, pins_s2_reg.sck) | went_high(pins_d_reg.sck, pins_s2_reg.sck);

   // The configuration bits are static levels on this clock and need no synchroniser.
   // The shared reset role is ignored while the pin serves as pause or as data.
   assign pause_pin_en = shared_pin_pauses(cfg);
   assign reset_pin_en = shared_pin_resets(cfg);
   assign shared_reset_low = reset_pin_en & ~pins_s2_reg.reset_n;
   assign any_reset_low = shared_reset_low | ~pins_s2_reg.ded_reset_n;
   assign hw_reset_fire = any_reset_low && (pin_low_cnt_reg == CNT_W'(RESET_PULSE_CYCLES - 1));

   // Low time of the reset pins, counted to qualify a pulse.
   // The count saturates, so a long low level fires the reset only once.
   always_ff @(posedge sys_clk) begin
      if (srst || !any_reset_low) begin
         pin_low_cnt_reg <= '0;
      end else if (pin_low_cnt_reg != CNT_W'(RESET_PULSE_CYCLES)) begin
         pin_low_cnt_reg <= pin_low_cnt_reg + 1'b1;
      end
   end

   // Four-pulse sequence on chip select; a clock edge abandons it.
   // A frame that saw any clock edge cannot open a new sequence either.
   always_ff @(posedge sys_clk) begin
      if (srst || iface_reset_reg) begin
         pulse_cnt_reg <= '0;
         pulse_bits_reg <= '0;
         pulse_sck_seen_reg <= 1'b0;
      end else if (sck_edge) begin
         pulse_cnt_reg <= '0;
         pulse_bits_reg <= '0;
         pulse_sck_seen_reg <= 1'b1;
      end else if (cs_fall) begin
         pulse_sck_seen_reg <= 1'b0;
      end else if (cs_rise) begin
         if (pulse_sck_seen_reg) begin
            pulse_cnt_reg <= '0;
            pulse_bits_reg <= '0;
         end else if (pulse_cnt_reg == 3'd4) begin
            pulse_cnt_reg <= 3'd1;
            pulse_bits_reg <= pulse_shift(4'h0, pins_s2_reg.si);
         end else begin
            pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
            pulse_bits_reg <= pulse_shift(pulse_bits_reg, pins_s2_reg.si);
         end
         pulse_sck_seen_reg <= 1'b0;
      end
   end

   // Fires on the fourth clean rise itself, so the interface reset is one cycle long.
   assign pulse_reset_fire = cs_rise && !sck_edge && !pulse_sck_seen_reg && (pulse_cnt_reg == 3'd3) &&
      (pulse_shift(pulse_bits_reg, pins_s2_reg.si) == PULSE_RESET_PATTERN);

   // Commands are refused while powering, in reset, in the soft reset wait or deselected.
   assign accept_cmds = (state_reg == ST_IDLE) && !por_s2_reg && !any_reset_low && sel_reg;
   assign soft_reset_fire = cmd_match(accept_cmds && cmd_valid, cmd_code, CMD_RESET) && en_reset_reg;

   // Enable-reset must be the very command before reset, in either command mode.
   // Any other accepted command in between disarms it.
   always_ff @(posedge sys_clk) begin
      if (srst || iface_reset_reg) begin
         en_reset_reg <= 1'b0;
      end else if (accept_cmds && cmd_valid) begin
         en_reset_reg <= cmd_match(1'b1, cmd_code, CMD_ENABLE_RESET);
      end
   end

   // Main reset state; hardware reset is checked after power-on and outranks commands.
   // A pin reset returns to idle at once and needs no recovery wait.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= ST_POR;
         soft_cnt_reg <= '0;
      end else if (por_s2_reg) begin
         state_reg <= ST_POR;
         soft_cnt_reg <= '0;
      end else if (hw_reset_fire) begin
         state_reg <= ST_IDLE;
         soft_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_POR: begin
               state_reg <= ST_IDLE;
            end
            ST_IDLE: begin
               if (soft_reset_fire) begin
                  state_reg <= ST_SOFT_WAIT;
                  soft_cnt_reg <= '0;
               end
            end
            ST_SOFT_WAIT: begin
               if (soft_cnt_reg == CNT_W'(SOFT_RESET_CYCLES_P - 1)) begin
                  state_reg <= ST_IDLE;
                  soft_cnt_reg <= '0;
               end else begin
                  soft_cnt_reg <= soft_cnt_reg + 1'b1;
               end
            end
            default: begin
               state_reg <= ST_POR;
            end
         endcase
      end
   end

   // One-cycle interface reset pulse for every reset source.
   // The cause keeps the last real reset; a deselect in pause leaves it alone.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         iface_reset_reg <= 1'b1;
         reset_cause_reg <= 2'd0;
      end else begin
         iface_reset_reg <= 1'b0;
         if (state_reg == ST_POR && !por_s2_reg) begin
            iface_reset_reg <= 1'b1;
            reset_cause_reg <= 2'd0;
         end else if (hw_reset_fire) begin
            iface_reset_reg <= 1'b1;
            reset_cause_reg <= 2'd2;
         end else if (soft_reset_fire) begin
            iface_reset_reg <= 1'b1;
            reset_cause_reg <= 2'd1;
         end else if (pulse_reset_fire) begin
            iface_reset_reg <= 1'b1;
            reset_cause_reg <= 2'd3;
         end else if (pause_reg && cs_rise) begin
            iface_reset_reg <= 1'b1;
         end
      end
   end

   // Selection needs a chip select fall seen after reset.
   // A select line already low at a power-on or pin reset release therefore does not select the device.
   always_ff @(posedge sys_clk) begin
      if (srst || por_s2_reg || any_reset_low) begin
         armed_reg <= 1'b0;
         sel_reg <= 1'b0;
      end else if (cs_fall) begin
         armed_reg <= 1'b1;
         sel_reg <= 1'b1;
      end else if (pins_s2_reg.cs_n) begin
         sel_reg <= 1'b0;
      end else begin
         sel_reg <= armed_reg & ~pins_s2_reg.cs_n;
      end
   end

   // Pause entry and exit only while the serial clock is low.
   // Deselecting also drops the pause, since the interface is reset then.
   always_ff @(posedge sys_clk) begin
      if (srst || iface_reset_reg || !pause_pin_en || !sel_reg) begin
         pause_reg <= 1'b0;
      end else if (!pins_s2_reg.sck) begin
         if (!pause_reg && !pins_s2_reg.pause_n) begin
            pause_reg <= 1'b1;
         end else if (pause_reg && pins_s2_reg.pause_n) begin
            pause_reg <= 1'b0;
         end
      end
   end

   // First clock edge of each selection unlocks output.
   // Edges during a pause do not count, as the clock is ignored then.
   always_ff @(posedge sys_clk) begin
      if (srst || iface_reset_reg || !sel_reg) begin
         first_edge_reg <= 1'b0;
      end else if (sck_edge && !pause_reg) begin
         first_edge_reg <= 1'b1;
      end
   end

   // A running write cycle keeps the device in active power after deselection.
   assign selected = sel_reg;
   assign active_power = sel_reg | write_busy;
   assign standby = ~sel_reg & ~write_busy;
   assign pause_active = pause_reg;
   assign out_allowed = first_edge_reg & sel_reg;
   assign so_oe = first_edge_reg & sel_reg & ~pause_reg;
   assign iface_reset = iface_reset_reg;
   assign soft_reset_busy = (state_reg == ST_SOFT_WAIT);
   assign reset_cause = reset_cause_reg;
endmodule : serial_flash_reset_hold_ctrl

`default_nettype wire

/* File: srhc_asserts.sv */
// Concurrent checks on the ports of the flash reset and hold controller.
`default_nettype none
module srhc_asserts import flash_reset_pkg::*; #(parameter int unsigned SOFT_RESET_CYCLES_P = 20) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic por_active,
   input wire flash_reset_pkg::cfg_t cfg,
   input wire logic write_busy,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic selected,
   input wire logic active_power,
   input wire logic standby,
   input wire logic pause_active,
   input wire logic so_oe,
   input wire logic out_allowed,
   input wire logic accept_cmds,
   input wire logic iface_reset,
   input wire logic soft_reset_busy,
   input wire logic [1:0] reset_cause
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   a_sel_active: assert property (selected |-> active_power && !standby) else $error("select not active");
   a_standby_idle: assert property (!selected |-> standby == !write_busy && active_power == write_busy)
      else $error("standby wrong");
   a_deselect_pause: assert property ($fell(selected) |=> !pause_active) else $error("pause kept");
   a_pause_quiet: assert property (pause_active |-> !so_oe) else $error("output in pause");
   a_oe_first: assert property (so_oe |-> out_allowed && selected) else $error("early output");
   a_soft_accept: assert property (cmd_valid && accept_cmds && cmd_code == CMD_RESET &&
      $past(cmd_valid && accept_cmds && cmd_code == CMD_ENABLE_RESET) |=> soft_reset_busy) else $error("no soft reset");
   a_busy_refuse: assert property (soft_reset_busy |-> !accept_cmds) else $error("command in reset");
   a_quad_nopause: assert property (cfg.quad_enable [*2] |-> !pause_active) else $error("pause in quad");
   a_por_mute: assert property (por_active [*3] |-> !accept_cmds) else $error("command in power-on");
   cover property ($rose(soft_reset_busy));
   cover property ($rose(pause_active));
   cover property (iface_reset && reset_cause == 2'h3);
endmodule : srhc_asserts
bind serial_flash_reset_hold_ctrl srhc_asserts #(.SOFT_RESET_CYCLES_P(SOFT_RESET_CYCLES_P)) u_chk (
   .sys_clk, .srst, .por_active, .cfg, .write_busy, .cmd_valid, .cmd_code, .selected, .active_power, .standby,
   .pause_active, .so_oe, .out_allowed, .accept_cmds, .iface_reset, .soft_reset_busy, .reset_cause);
`default_nettype wire

/* File: spi_host_model.sv */
// Host serial master model driving the flash select, clock, data and reset pins.
`default_nettype none
module spi_host_model import flash_reset_pkg::*; (
   input wire logic sys_clk,
   output var flash_reset_pkg::pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Deselected, clock idle low, pause and reset lines released high.
   initial pins = 6'h2F;
   task automatic drive(input int idx, input logic v);
      @(negedge sys_clk);
      pins[idx] = v;
   endtask : drive
   // One select frame; the clock stands still unless edges are asked for.
   task automatic frame(input logic v, input int edges);
      @(negedge sys_clk);
      pins.cs_n = 1'b0;
      pins.si = v;
      repeat (4) @(negedge sys_clk);
      repeat (edges) begin
         pins.sck = ~pins.sck;
         repeat (4) @(negedge sys_clk);
      end
      pins.cs_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      pins.si = ~v;
      repeat (4) @(negedge sys_clk);
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* File: test_serial_flash_reset_hold_ctrl.sv */
// Self-checking testbench for the flash reset and hold controller.
`default_nettype none
module test_serial_flash_reset_hold_ctrl import flash_reset_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, srst = 1'b1, por_active = 1'b1, write_busy = 1'b0, cmd_valid = 1'b0, hit;
   logic [7:0] cmd_code = 8'h00;
   cfg_t cfg = 3'h0;
   pins_t pins;
   logic selected, active_power, standby, pause_active, so_oe, out_allowed, accept_cmds, iface_reset, soft_reset_busy;
   logic [1:0] reset_cause;
   logic [4:0] rows [4] = '{5'h02, 5'h0B, 5'h1A, 5'h19};
   int failures = 0, tests_run = 0, cyc = 0;
   always #10 sys_clk = ~sys_clk;
   serial_flash_reset_hold_ctrl #(.SOFT_RESET_CYCLES_P(20)) DUT (.sys_clk, .srst, .por_active, .pins, .cfg,
      .write_busy, .cmd_valid, .cmd_code, .selected, .active_power, .standby, .pause_active, .so_oe,
      .out_allowed, .accept_cmds, .iface_reset, .soft_reset_busy, .reset_cause);
   spi_host_model host (.sys_clk, .pins);
   task automatic results();
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s exp %0h got %0h", name, exp, got);
      end
   endtask : chk
   task automatic wait_ir(input int n, output logic seen);
      seen = 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         #1 if (iface_reset === 1'b1) seen = 1'b1;
      end
   endtask : wait_ir
   task automatic send(input logic [23:0] codes);
      for (int i = 2; i >= 0; i--) begin
         @(negedge sys_clk);
         cmd_valid = 1'b1;
         cmd_code = codes[i*8 +: 8];
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask : send
   task automatic reselect();
      host.drive(5, 1'b1);
      repeat (3) @(negedge sys_clk);
      host.drive(5, 1'b0);
      repeat (6) @(negedge sys_clk);
   endtask : reselect
   task automatic t_power();
      host.drive(5, 1'b0);
      por_active = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("accept_cmds", 0, accept_cmds);
      send(24'h669900);
      chk("soft_reset_busy", 0, soft_reset_busy);
      por_active = 1'b0;
      wait_ir(10, hit);
      chk("iface_reset", 1, hit);
      chk("reset_cause", 0, reset_cause);
      chk("selected", 0, selected);
      chk("standby", 1, standby);
      @(negedge sys_clk);
      write_busy = 1'b1;
      @(negedge sys_clk);
      chk("active_power", 1, active_power);
      chk("standby", 0, standby);
      write_busy = 1'b0;
      reselect();
      chk("selected", 1, selected);
      chk("active_power", 1, active_power);
   endtask : t_power
   task automatic t_soft();
      for (int m = 0; m < 2; m++) begin
         cfg.four_wire_command_mode = m[0];
         reselect();
         send(24'h669900);
         chk("soft_reset_busy", 1, soft_reset_busy);
         chk("reset_cause", 1, reset_cause);
         repeat (15) @(negedge sys_clk);
         chk("accept_cmds", 0, accept_cmds);
         repeat (10) @(negedge sys_clk);
         chk("soft_reset_busy", 0, soft_reset_busy);
      end
      reselect();
      send(24'h660599);
      chk("soft_reset_busy", 0, soft_reset_busy);
   endtask : t_soft
   task automatic t_pause();
      cfg = 3'h0;
      reselect();
      host.drive(2, 1'b0);
      repeat (6) @(negedge sys_clk);
      chk("pause_active", 1, pause_active);
      chk("so_oe", 0, so_oe);
      host.drive(2, 1'b1);
      repeat (6) @(negedge sys_clk);
      chk("pause_active", 0, pause_active);
      host.drive(2, 1'b0);
      repeat (6) @(negedge sys_clk);
      host.drive(5, 1'b1);
      wait_ir(8, hit);
      chk("iface_reset", 1, hit);
      host.drive(2, 1'b1);
      cfg = 3'h4;
      reselect();
      host.drive(2, 1'b0);
      repeat (6) @(negedge sys_clk);
      chk("pause_active", 0, pause_active);
      host.drive(2, 1'b1);
   endtask : t_pause
   task automatic t_pins();
      foreach (rows[i]) begin
         cfg = rows[i][4:2];
         reselect();
         host.drive(rows[i][1] ? 1 : 0, 1'b0);
         wait_ir(60, hit);
         chk("iface_reset", rows[i][0], hit);
         chk("accept_cmds", !rows[i][0], accept_cmds);
         host.drive(rows[i][1] ? 1 : 0, 1'b1);
      end
      chk("reset_cause", 2, reset_cause);
   endtask : t_pins
   task automatic t_four();
      cfg = 3'h0;
      host.frame(1'b0, 2);
      for (int i = 0; i < 4; i++) host.frame(i[0], i == 3 ? 2 : 0);
      chk("reset_cause", 2, reset_cause);
      for (int i = 0; i < 3; i++) host.frame(i[0], 0);
      chk("reset_cause", 2, reset_cause);
      host.frame(1'b1, 0);
      chk("reset_cause", 3, reset_cause);
   endtask : t_four
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      srst = 1'b0;
      t_power();
      t_soft();
      t_pause();
      t_pins();
      t_four();
      t_power();
      results();
   end
endmodule : test_serial_flash_reset_hold_ctrl
`default_nettype wire
